/* rtl/sltd_pkg.sv */
// constants and field layout for the serial latch driver
// How it works
// - eight-bit shift register feeds an eight-bit storage register.
// - each shift clock rising edge shifts serial input in by one.
// - each latch clock rising edge copies shift into storage.
// - master clear low empties both registers without any clock edge.
// - tied clocks: storage takes the shift value from before that shift.
// - cascade output changes on the shift clock falling edge, and clears on master clear low.
// - enable low: a set storage bit turns its drain on, pulling low.
// - enable high: all eight drains are off regardless of storage.
// - output enable never alters shift or storage contents.
package sltd_pkg;
    localparam int unsigned SLTD_WIDTH = 8;
    localparam int unsigned SLTD_FIFO_DEPTH = 2;
    localparam int unsigned SLTD_PIN_COUNT = 5;
    // pin order inside the synchroniser vector
    localparam int unsigned SLTD_PIN_SER = 0;
    localparam int unsigned SLTD_PIN_SHCLK = 1;
    localparam int unsigned SLTD_PIN_LTCLK = 2;
    localparam int unsigned SLTD_PIN_CLR_N = 3;
    localparam int unsigned SLTD_PIN_OE_N = 4;
    localparam logic [4:0] SLTD_PIN_RESET = 5'h18;
    // register byte offsets
    localparam logic [7:0] SLTD_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SLTD_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SLTD_SNAP_OFFSET = 8'h08;
    // control fields
    localparam int unsigned SLTD_CTRL_CAPTURE_BIT = 0;
    localparam logic SLTD_CTRL_CAPTURE_RESET = 1'b0;
    // status fields
    localparam int unsigned SLTD_STAT_SHIFT_LSB = 0;
    localparam int unsigned SLTD_STAT_STORE_LSB = 8;
    localparam int unsigned SLTD_STAT_CASCADE_BIT = 16;
    localparam int unsigned SLTD_STAT_OE_N_BIT = 17;
    localparam int unsigned SLTD_STAT_CLEAR_BIT = 18;
    localparam int unsigned SLTD_STAT_OVERRUN_BIT = 19;
    localparam int unsigned SLTD_STAT_AVAIL_BIT = 20;
    // snapshot fields
    localparam int unsigned SLTD_SNAP_VALID_BIT = 8;
    // bus responses
    localparam logic [1:0] SLTD_RESP_OKAY = 2'h0;
    localparam logic [1:0] SLTD_RESP_SLVERR = 2'h2;
endpackage

/* rtl/sltd_stream_if.sv */
// valid/ready stream between the capture logic and its buffer
`timescale 1ns/10ps
interface sltd_stream_if #(
    parameter int unsigned W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface

/* rtl/sltd_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module sltd_sync #(
    parameter int unsigned W = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // levels
    input logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // sltd_sync

/* rtl/sltd_fifo.sv */
// small valid/ready buffer with honest full and empty
`timescale 1ns/10ps
module sltd_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // streams
    sltd_stream_if.consumer in_s,
    sltd_stream_if.producer out_s
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    assign in_s.ready = (count_q != FULL);
    assign out_s.valid = (count_q != '0);
    assign out_s.data = mem_q[rd_q];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            case ({push, pop})
                2'b10: count_q <= count_q + 1'b1;
                2'b01: count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end
endmodule // sltd_fifo

/* rtl/sltd_top.sv */
// serial-in latch driver with open-drain outputs and an AXI4-Lite port
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module sltd_top (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // device pins
    input logic serial_in_i,
    input logic shift_clock_i,
    input logic latch_clock_i,
    input logic master_clear_n_i,
    input logic output_enable_n_i,
    output logic cascade_out_o,
    output logic [7:0] drain_out_o,
    output logic [7:0] drain_oe_o,
    // snapshot buffer can take a word
    output logic snap_ready_o,
    // axi4-lite write
    input logic [31:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // axi4-lite read
    input logic [31:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready
);
    localparam int unsigned W = sltd_pkg::SLTD_WIDTH;

    // synchronised pins
    logic [sltd_pkg::SLTD_PIN_COUNT-1:0] pins_raw;
    logic [sltd_pkg::SLTD_PIN_COUNT-1:0] pins_s;
    logic ser_s;
    logic shclk_s;
    logic ltclk_s;
    logic clr_n_s;
    logic oe_n_s;
    logic shclk_prev_q;
    logic ltclk_prev_q;
    logic sh_rise;
    logic sh_fall;
    logic lt_rise;
    logic clear_act;

    // device state
    logic [W-1:0] shift_q;
    logic [W-1:0] store_q;
    logic cascade_q;
    logic [W-1:0] drain_oe_q;
    logic [W-1:0] drain_out_q;

    // software state
    logic capture_en_q;
    logic overrun_q;
    logic snap_ready_q;
    logic overrun_set;
    logic overrun_clr;

    // bus state
    logic awready_q;
    logic wready_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    logic ar_hs;
    logic [7:0] araddr_lo;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    sltd_stream_if #(.W(W)) cap_s ();
    sltd_stream_if #(.W(W)) snap_s ();

    assign pins_raw = {output_enable_n_i, master_clear_n_i, latch_clock_i,
                       shift_clock_i, serial_in_i};

    sltd_sync #(
        .W(sltd_pkg::SLTD_PIN_COUNT),
        .RST_VAL(sltd_pkg::SLTD_PIN_RESET)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    sltd_fifo #(
        .W(W),
        .DEPTH(sltd_pkg::SLTD_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_s(cap_s),
        .out_s(snap_s)
    );

    assign ser_s = pins_s[sltd_pkg::SLTD_PIN_SER];
    assign shclk_s = pins_s[sltd_pkg::SLTD_PIN_SHCLK];
    assign ltclk_s = pins_s[sltd_pkg::SLTD_PIN_LTCLK];
    assign clr_n_s = pins_s[sltd_pkg::SLTD_PIN_CLR_N];
    assign oe_n_s = pins_s[sltd_pkg::SLTD_PIN_OE_N];

    // serial data passes the same two stages as the clock, so it stays aligned
    assign sh_rise = shclk_s & ~shclk_prev_q;
    assign sh_fall = ~shclk_s & shclk_prev_q;
    assign lt_rise = ltclk_s & ~ltclk_prev_q;
    assign clear_act = ~clr_n_s;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shclk_prev_q <= 1'b0;
            ltclk_prev_q <= 1'b0;
        end else begin
            shclk_prev_q <= shclk_s;
            ltclk_prev_q <= ltclk_s;
        end
    end

    // shift stage; oe is not read here
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_act) begin
            shift_q <= '0;
        end else if (sh_rise) begin
            shift_q <= {shift_q[W-2:0], ser_s};
        end
    end

    // storage stage samples the old shift value when both edges coincide
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_act) begin
            store_q <= '0;
        end else if (lt_rise) begin
            store_q <= shift_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_act) begin
            cascade_q <= 1'b0;
        end else if (sh_fall) begin
            cascade_q <= shift_q[W-1];
        end
    end

    // open drain: pin level is never driven high, only released
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drain_oe_q <= '0;
            drain_out_q <= '0;
        end else begin
            drain_oe_q <= store_q & {W{~oe_n_s}};
            drain_out_q <= '0;
        end
    end

    // the latch edge cannot wait, so a full buffer drops the word
    assign cap_s.valid = lt_rise & capture_en_q & ~clear_act;
    assign cap_s.data = shift_q;
    assign overrun_set = cap_s.valid & ~cap_s.ready;
    assign overrun_clr = do_write &&
                         awaddr_q == sltd_pkg::SLTD_STATUS_OFFSET &&
                         wstrb_q[2] &&
                         wdata_q[sltd_pkg::SLTD_STAT_OVERRUN_BIT];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            overrun_q <= 1'b0;
            snap_ready_q <= 1'b0;
        end else begin
            overrun_q <= overrun_set | (overrun_q & ~overrun_clr);
            snap_ready_q <= cap_s.ready;
        end
    end

    // write channel: address and data taken in either order
    assign do_write = aw_got_q & w_got_q & ~bvalid_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= sltd_pkg::SLTD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_got_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (awaddr_q == sltd_pkg::SLTD_CTRL_OFFSET ||
                    awaddr_q == sltd_pkg::SLTD_STATUS_OFFSET) begin
                    bresp_q <= sltd_pkg::SLTD_RESP_OKAY;
                end else begin
                    bresp_q <= sltd_pkg::SLTD_RESP_SLVERR;
                end
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            capture_en_q <= sltd_pkg::SLTD_CTRL_CAPTURE_RESET;
        end else if (do_write && awaddr_q == sltd_pkg::SLTD_CTRL_OFFSET &&
                     wstrb_q[0]) begin
            capture_en_q <= wdata_q[sltd_pkg::SLTD_CTRL_CAPTURE_BIT];
        end
    end

    // read channel; a snapshot read pops the buffer
    assign ar_hs = s_axi_arvalid & arready_q;
    assign araddr_lo = {s_axi_araddr[7:2], 2'h0};
    assign snap_s.ready = ar_hs && araddr_lo == sltd_pkg::SLTD_SNAP_OFFSET;

    always_comb begin
        rd_word = '0;
        rd_resp = sltd_pkg::SLTD_RESP_OKAY;
        case (araddr_lo)
            sltd_pkg::SLTD_CTRL_OFFSET: begin
                rd_word[sltd_pkg::SLTD_CTRL_CAPTURE_BIT] = capture_en_q;
            end
            sltd_pkg::SLTD_STATUS_OFFSET: begin
                rd_word[sltd_pkg::SLTD_STAT_SHIFT_LSB +: W] = shift_q;
                rd_word[sltd_pkg::SLTD_STAT_STORE_LSB +: W] = store_q;
                rd_word[sltd_pkg::SLTD_STAT_CASCADE_BIT] = cascade_q;
                rd_word[sltd_pkg::SLTD_STAT_OE_N_BIT] = oe_n_s;
                rd_word[sltd_pkg::SLTD_STAT_CLEAR_BIT] = clear_act;
                rd_word[sltd_pkg::SLTD_STAT_OVERRUN_BIT] = overrun_q;
                rd_word[sltd_pkg::SLTD_STAT_AVAIL_BIT] = snap_s.valid;
            end
            sltd_pkg::SLTD_SNAP_OFFSET: begin
                rd_word[W-1:0] = snap_s.valid ? snap_s.data : '0;
                rd_word[sltd_pkg::SLTD_SNAP_VALID_BIT] = snap_s.valid;
            end
            default: begin
                rd_resp = sltd_pkg::SLTD_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= sltd_pkg::SLTD_RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign cascade_out_o = cascade_q;
    assign drain_out_o = drain_out_q;
    assign drain_oe_o = drain_oe_q;
    assign snap_ready_o = snap_ready_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule // sltd_top

/* testbench/sltd_properties.sv */
// port-level assertions for the serial latch driver
`timescale 1ns/10ps
module sltd_properties (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // device pins
    input logic shift_clock_i,
    input logic latch_clock_i,
    input logic master_clear_n_i,
    input logic output_enable_n_i,
    input logic cascade_out_o,
    input logic [7:0] drain_out_o,
    input logic [7:0] drain_oe_o,
    // bus handshakes
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // cycles since each shift clock fall and each latch, enable or clear change, saturating; pins pass a synchroniser
    logic shp_q, ltp_q, oep_q, clp_q;
    logic [3:0] sha_q, lta_q, oea_q, cla_q;
    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : a + 4'(a != 4'hF);
    endfunction
    always_ff @(posedge clk_i) begin
        shp_q <= shift_clock_i;
        ltp_q <= latch_clock_i;
        oep_q <= output_enable_n_i;
        clp_q <= master_clear_n_i;
    end
    always_ff @(posedge clk_i) begin
        sha_q <= rst_n_i ? age(shp_q & ~shift_clock_i, sha_q) : 4'hF;
        lta_q <= rst_n_i ? age(ltp_q ^ latch_clock_i, lta_q) : 4'hF;
        oea_q <= rst_n_i ? age(oep_q ^ output_enable_n_i, oea_q) : 4'hF;
        cla_q <= rst_n_i ? age(clp_q ^ master_clear_n_i, cla_q) : 4'hF;
    end
    oe_off_a: assert property (
        output_enable_n_i [*4] |-> drain_oe_o == 8'h00)
        else $error("drain on while outputs disabled");
    oe_gate_a: assert property (
        drain_oe_o != 8'h00 |-> !$past(output_enable_n_i, 3))
        else $error("drain on without enable");
    drain_val_a: assert property (
        drain_out_o == 8'h00)
        else $error("drain value not low");
    clear_hold_a: assert property (
        !master_clear_n_i [*6] |-> drain_oe_o == 8'h00 && !cascade_out_o)
        else $error("outputs not cleared");
    casc_fall_a: assert property (
        $changed(cascade_out_o) |-> sha_q <= 4'h6 || cla_q <= 4'h6)
        else $error("cascade moved without shift fall");
    drain_quiet_a: assert property (
        $changed(drain_oe_o) |-> lta_q <= 4'h7 || oea_q <= 4'h5
            || cla_q <= 4'h6)
        else $error("drain moved without cause");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    write_busy_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not next cycle");
    read_done_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not withdrawn");
    cover property (!master_clear_n_i [*6]);
    cover property ($fell(cascade_out_o));
    cover property (drain_oe_o != 8'h00 ##1 drain_oe_o == 8'h00);
endmodule // sltd_properties

bind sltd_top sltd_properties sltd_properties_inst (.clk_i, .rst_n_i,
    .shift_clock_i, .latch_clock_i, .master_clear_n_i, .output_enable_n_i,
    .cascade_out_o, .drain_out_o, .drain_oe_o, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);

/* testbench/sltd_host_model.sv */
// host-side pin driver feeding the latch driver
`timescale 1ns/10ps
module sltd_host_model #(
    parameter int HALF = 6
) (
    // clock
    input logic clk_i,
    // pins
    input logic cascade_out_i,
    output logic serial_in_o,
    output logic shift_clock_o,
    output logic latch_clock_o,
    output logic master_clear_n_o,
    output logic output_enable_n_o
);
    initial begin
        serial_in_o = 1'b0;
        shift_clock_o = 1'b0;
        latch_clock_o = 1'b0;
        master_clear_n_o = 1'b1;
        output_enable_n_o = 1'b1;
    end
    // half a pin clock period; the device needs three cycles per level
    task automatic wait_half();
        repeat (HALF) @(posedge clk_i);
    endtask
    task automatic pulse(input logic sh, input logic lt);
        shift_clock_o <= sh;
        latch_clock_o <= lt;
        wait_half();
        shift_clock_o <= 1'b0;
        latch_clock_o <= 1'b0;
        wait_half();
    endtask
    // msb first so the first bit lands in stage 7; cascade read per fall
    task automatic send_byte(input logic [7:0] b, output logic [7:0] casc);
        for (int i = 7; i >= 0; i--) begin
            serial_in_o <= b[i];
            wait_half();
            pulse(1'b1, 1'b0);
            casc[i] = cascade_out_i;
        end
        // a released data line must not look like a held bit
        serial_in_o <= ~b[0];
        wait_half();
    endtask
    task automatic tied_bit(input logic b);
        serial_in_o <= b;
        wait_half();
        pulse(1'b1, 1'b1);
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        master_clear_n_o <= clr_n;
        output_enable_n_o <= oe_n;
        wait_half();
    endtask
endmodule // sltd_host_model

/* testbench/test_sltd_top.sv */
// self-checking bench for the serial latch driver
`timescale 1ns/10ps
module test_sltd_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic serial_in_i, shift_clock_i, latch_clock_i;
    logic master_clear_n_i, output_enable_n_i, cascade_out_o, snap_ready_o;
    logic [7:0] drain_out_o, drain_oe_o, casc;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0;
    int checks_done = 0;
    always #50 clk_i = ~clk_i;
    sltd_host_model sltd_host_model_inst (.clk_i,
        .cascade_out_i(cascade_out_o), .serial_in_o(serial_in_i),
        .shift_clock_o(shift_clock_i), .latch_clock_o(latch_clock_i),
        .master_clear_n_o(master_clear_n_i),
        .output_enable_n_o(output_enable_n_i));
    sltd_top sltd_top_inst (.clk_i, .rst_n_i, .serial_in_i, .shift_clock_i,
        .latch_clock_i, .master_clear_n_i, .output_enable_n_i,
        .cascade_out_o, .drain_out_o, .drain_oe_o, .snap_ready_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] st(input logic [7:0] sh, sto,
        input logic ca, oen, clr, ovr, av);
        return {11'h0, av, ovr, clr, oen, ca, sto, sh};
    endfunction
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        logic [1:0] r;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
        check("bresp", 32'(r), 32'(er));
    endtask
    task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
        check("rresp", 32'(r), 32'(er));
        check("rdata", d, exp);
    endtask
    task automatic t_regs();
        rd(32'h00, 32'h0, 2'h0);
        rd(32'h04, st(8'h00, 8'h00, 0, 1, 0, 0, 0), 2'h0);
        rd(32'h10, 32'h0, 2'h2);
        wr(32'h08, 32'h1, 2'h2);
        wr(32'h00, 32'h1, 2'h0);
        rd(32'h00, 32'h1, 2'h0);
        wr(32'h00, 32'h0, 2'h0);
    endtask
    task automatic t_shift();
        logic [7:0] a, b;
        a = 8'hA5;
        b = 8'h3C;
        sltd_host_model_inst.set_pins(1'b1, 1'b0);
        sltd_host_model_inst.send_byte(a, casc);
        sltd_host_model_inst.send_byte(b, casc);
        check("cascade", 32'(casc), 32'({a[6:0], b[7]}));
        check("drain unlatched", 32'(drain_oe_o), 32'h0);
        sltd_host_model_inst.pulse(1'b0, 1'b1);
        check("drain latched", 32'(drain_oe_o), 32'(b));
        check("drain level", 32'(drain_out_o), 32'h0);
        rd(32'h04, st(b, b, b[7], 0, 0, 0, 0), 2'h0);
    endtask
    task automatic t_oe();
        sltd_host_model_inst.set_pins(1'b1, 1'b1);
        check("drain disabled", 32'(drain_oe_o), 32'h0);
        rd(32'h04, st(8'h3C, 8'h3C, 0, 1, 0, 0, 0), 2'h0);
        sltd_host_model_inst.set_pins(1'b1, 1'b0);
        check("drain enabled", 32'(drain_oe_o), 32'h3C);
    endtask
    task automatic t_tied();
        logic [7:0] a, s;
        a = 8'hC3;
        s = {a[6:0], 1'b1};
        sltd_host_model_inst.send_byte(a, casc);
        sltd_host_model_inst.tied_bit(1'b1);
        check("tied drain", 32'(drain_oe_o), 32'(a));
        rd(32'h04, st(s, a, s[7], 0, 0, 0, 0), 2'h0);
    endtask
    task automatic t_clear();
        sltd_host_model_inst.set_pins(1'b0, 1'b0);
        sltd_host_model_inst.tied_bit(1'b1);
        check("clear drain", 32'(drain_oe_o), 32'h0);
        check("clear cascade", 32'(cascade_out_o), 32'h0);
        rd(32'h04, st(8'h00, 8'h00, 0, 0, 1, 0, 0), 2'h0);
        sltd_host_model_inst.set_pins(1'b1, 1'b0);
        check("after clear", 32'(drain_oe_o), 32'h0);
    endtask
    // buffer is left unread while three words arrive, so the third drops
    task automatic t_snap();
        wr(32'h00, 32'h1, 2'h0);
        for (int i = 1; i <= 3; i++) begin
            sltd_host_model_inst.send_byte(8'(i * 8'h11), casc);
            sltd_host_model_inst.pulse(1'b0, 1'b1);
        end
        check("buffer full", 32'(snap_ready_o), 32'h0);
        rd(32'h04, st(8'h33, 8'h33, 0, 0, 0, 1, 1), 2'h0);
        rd(32'h08, 32'h111, 2'h0);
        rd(32'h08, 32'h122, 2'h0);
        rd(32'h08, 32'h000, 2'h0);
        check("buffer free", 32'(snap_ready_o), 32'h1);
        wr(32'h04, 32'h0008_0000, 2'h0);
        rd(32'h04, st(8'h33, 8'h33, 0, 0, 0, 0, 0), 2'h0);
        wr(32'h00, 32'h0, 2'h0);
    endtask
    task automatic finish_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_shift();
        t_oe();
        t_tied();
        t_clear();
        t_snap();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
endmodule // test_sltd_top
